// File: inc/ccos_params.svh
// Constants of the channel operation sequencer
// Notes on behaviour
// - Raw transmit writes data, no status merge
// - Raw receive reads data, no status copy
// - Sync search: control byte receive-on low, then high
// - Copy last-block bit on first memory transfer
// - Last-block branches test the copied bit
// - Load without descriptor stalls lower channels
// - Late descriptor flags service error bit four
// - Wait saves context, restores on channel request
// - Restore loads character size into CRC
// - Address and range keep counting past end
// - Host interrupt clears byte, sets bit zero
// - Start ignores valid; only transfers flag error
// - Get-next-block clears the valid bit
// - Scan active only with scan enable bit
// - Masked status compared with masked previous
// - Line status overwrites stored previous status
// - Change sets status-change flag bit three
// - Change starts channel program when enabled
// - Change interrupts host; interrupt wins
// - Scan only while channel program idle
// - Normal send ORs status bit seven
// - Normal receive ORs status bit six
`ifndef CCOS_PARAMS_SVH
`define CCOS_PARAMS_SVH
`define CCOS_NCH        4
`define CCOS_CHW        2
`define CCOS_TBL_CFG_RX 6'h02
`define CCOS_TBL_CFG_TX 6'h22
`define CCOS_TBL_SCAN   6'h08
`define CCOS_TBL_PREV   6'h0e
`define CCOS_TBL_MASK   6'h0f
`define CCOS_TBL_STAT   6'h10
`define CCOS_TBL_CHG    6'h11
`define CCOS_TBL_CTRL   6'h14
`define CCOS_TX_OFS     6'h20
`define CCOS_BIT_RXON   3'd2
`define CCOS_BIT_SVCERR 3'd4
`define CCOS_BIT_ERR    3'd2
`define CCOS_BIT_SEND   3'd7
`define CCOS_BIT_RECEIVE_CHAR_OP   3'd6
`define CCOS_BIT_CHG    3'd3
`define CCOS_BIT_SCANEN 3'd0
`define CCOS_BIT_SCANINT 3'd2
`define CCOS_BIT_SCANST 3'd3
`define CCOS_BIT_SCANIRQ 3'd1
`define CCOS_BIT_DVALID 3'd1
`define CCOS_BIT_DLAST  3'd2
`define CCOS_TBL_DEPTH  64
`define CCOS_CSIZE_MSK  8'h03
`define CCOS_WAIT_NS    15000
`define CCOS_CLK_NS     100
`define CCOS_WAIT_CYC   (`CCOS_WAIT_NS / `CCOS_CLK_NS)
`endif

// File: inc/ccos_pkg.sv
// Types of the channel operation sequencer
package ccos_pkg;
  typedef enum logic [3:0] {
    CCOS_OP_NOP, CCOS_OP_SEND, CCOS_OP_RECEIVE_CHAR_OP, CCOS_OP_RAW_TX, CCOS_OP_RAW_RX,
    CCOS_OP_SYNC, CCOS_OP_LOAD, CCOS_OP_STORE, CCOS_OP_BLB, CCOS_OP_GNB,
    CCOS_OP_WAIT, CCOS_OP_HOST_INTERRUPT_OP, CCOS_OP_START, CCOS_OP_SCAN
  } ccos_op_t;
  typedef enum logic [2:0] {
    CCOS_IDLE, CCOS_SYNC_LO, CCOS_SYNC_HI, CCOS_WAITING, CCOS_RESTORE, CCOS_DONE
  } ccos_state_t;
endpackage : ccos_pkg

// File: design/ccos_sequencer.sv
// Per-channel operation sequencer with modem status scan
`timescale 1ns/1ps
`include "ccos_params.svh"
module ccos_sequencer
  import ccos_pkg::*;
(
  input  wire logic        mclk_i,        // 10 MHz clock
  input  wire logic        arst_n_i,      // Async reset, active low
  input  wire logic        op_valid_i,    // Operation request strobe
  input  wire logic [3:0]  op_code_i,     // Operation code
  input  wire logic [1:0]  op_chan_i,     // Channel number
  input  wire logic        op_tx_i,       // Transmit side of channel
  input  wire logic [7:0]  op_data_i,     // Character to send
  input  wire logic        chan_req_i,    // Channel request interrupt
  input  wire logic        desc_set_i,    // Host descriptor-control write
  input  wire logic [1:0]  desc_chan_i,   // Channel of descriptor write
  input  wire logic [7:0]  desc_ctrl_i,   // Descriptor control byte
  input  wire logic        tbl_we_i,      // Host table byte write
  input  wire logic [1:0]  tbl_chan_i,    // Table channel
  input  wire logic [5:0]  tbl_addr_i,    // Table byte address
  input  wire logic [7:0]  tbl_wdata_i,   // Table write data
  input  wire logic        tbl_re_i,      // Table byte read strobe
  output logic      [7:0]  tbl_rdata_o,   // Table read data, next cycle
  input  wire logic [7:0]  line_status_i, // Line status register value
  input  wire logic [7:0]  line_rx_i,     // Line data register read value
  output logic             line_wr_o,     // Line data register write pulse
  output logic             line_rd_o,     // Line data register read pulse
  output logic      [7:0]  line_wdata_o,  // Line data register write value
  output logic             ctrl_wr_o,     // Line control register write pulse
  output logic      [7:0]  ctrl_wdata_o,  // Line control register value
  output logic             crc_en_o,      // CRC and parity on this transfer
  output logic             crc_load_o,    // Load character size pulse
  output logic      [1:0]  crc_size_o,    // Character size for CRC
  output logic      [7:0]  rx_char_o,     // Received character
  output logic             last_blk_o,    // Copied last-block result
  output logic             desc_valid_o,  // Valid bit of addressed channel
  output logic      [15:0] buf_addr_o,    // Buffer address of op channel
  output logic      [15:0] buf_range_o,   // Remaining range of op channel
  output logic             busy_o,        // Sequencer busy
  output logic             stall_o,       // Lower channels starved
  output logic             host_irq_o,    // Host interrupt pulse
  output logic             prog_start_o,  // Channel program start pulse
  output logic      [1:0]  evt_chan_o     // Channel of irq or start
);
  logic [1:0]  rst_sync_q;
  logic        rst_n;
  logic [7:0]  tbl_q [`CCOS_NCH][`CCOS_TBL_DEPTH];
  logic [`CCOS_NCH-1:0] valid_q;
  logic [`CCOS_NCH-1:0] last_q;
  logic [`CCOS_NCH-1:0] lastcpy_q;
  logic [`CCOS_NCH-1:0] xfer_seen_q;
  logic [`CCOS_NCH-1:0] nodesc_q;
  logic [`CCOS_NCH-1:0] run_q;
  logic [15:0] addr_q [`CCOS_NCH];
  logic [15:0] range_q [`CCOS_NCH];
  logic [7:0]  ctx_q [`CCOS_NCH];
  ccos_state_t state_q;
  logic [1:0]  ch_q;
  logic [11:0] wcnt_q;
  logic [1:0]  scan_ch_q;
  logic        scan_tx_q;
  ccos_op_t    op;
  logic [7:0]  scan_ctl;
  logic [7:0]  cur_m;
  logic [7:0]  prev_m;
  logic [5:0]  sbase;
  logic        scan_go;
  logic        scan_hit;
  logic        desc_ok;
  logic        desc_late;

  assign op        = ccos_op_t'(op_code_i);
  assign rst_n     = rst_sync_q[1];
  assign desc_ok   = desc_set_i && desc_ctrl_i[`CCOS_BIT_DVALID];
  // Descriptor that releases a load stalled on this channel
  assign desc_late = desc_ok && state_q == CCOS_DONE && desc_chan_i == ch_q;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) rst_sync_q <= 2'b00;
    else           rst_sync_q <= {rst_sync_q[0], 1'b1};
  end

  // Scan side: both halves of every channel in turn, only while its program is idle
  assign sbase    = scan_tx_q ? `CCOS_TX_OFS : 6'h00;
  assign scan_ctl = tbl_q[scan_ch_q][sbase + `CCOS_TBL_SCAN];
  assign cur_m    = line_status_i & tbl_q[scan_ch_q][sbase + `CCOS_TBL_MASK];
  assign prev_m   = tbl_q[scan_ch_q][sbase + `CCOS_TBL_PREV] & tbl_q[scan_ch_q][sbase + `CCOS_TBL_MASK];
  assign scan_go  = scan_ctl[`CCOS_BIT_SCANEN] && !run_q[scan_ch_q]
                    && state_q == CCOS_IDLE && !op_valid_i;
  assign scan_hit = scan_go && (cur_m != prev_m);

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      scan_ch_q <= 2'd0;
      scan_tx_q <= 1'b0;
    end else begin
      scan_tx_q <= !scan_tx_q;
      if (scan_tx_q) scan_ch_q <= scan_ch_q + 2'd1;
    end
  end

  // Table storage, one bank per channel
  always_ff @(posedge mclk_i) begin
    if (tbl_we_i) tbl_q[tbl_chan_i][tbl_addr_i] <= tbl_wdata_i;
    if (scan_go) begin
      tbl_q[scan_ch_q][sbase + `CCOS_TBL_PREV] <= line_status_i;
      if (scan_hit) begin
        tbl_q[scan_ch_q][sbase + `CCOS_TBL_CHG][`CCOS_BIT_CHG] <= 1'b1;
        if (scan_ctl[`CCOS_BIT_SCANINT])
          tbl_q[scan_ch_q][sbase + `CCOS_TBL_STAT][`CCOS_BIT_SCANIRQ] <= 1'b1;
      end
    end
    if (op_valid_i && state_q == CCOS_IDLE) begin
      unique case (op)
        CCOS_OP_SEND:
          tbl_q[op_chan_i][`CCOS_TX_OFS + `CCOS_TBL_STAT][`CCOS_BIT_ERR] <=
            tbl_q[op_chan_i][`CCOS_TX_OFS + `CCOS_TBL_STAT][`CCOS_BIT_ERR] | line_status_i[`CCOS_BIT_SEND];
        CCOS_OP_RECEIVE_CHAR_OP:
          tbl_q[op_chan_i][`CCOS_TBL_STAT][`CCOS_BIT_ERR] <=
            tbl_q[op_chan_i][`CCOS_TBL_STAT][`CCOS_BIT_ERR] | line_status_i[`CCOS_BIT_RECEIVE_CHAR_OP];
        CCOS_OP_HOST_INTERRUPT_OP: tbl_q[op_chan_i][`CCOS_TBL_STAT] <= 8'h01;
        default: ;
      endcase
    end
    if (desc_ok && nodesc_q[desc_chan_i])
      tbl_q[desc_chan_i][`CCOS_TX_OFS + `CCOS_TBL_STAT][`CCOS_BIT_SVCERR] <= 1'b1;
  end

  // Descriptor state per channel
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      valid_q     <= '0;
      last_q      <= '0;
      lastcpy_q   <= '0;
      xfer_seen_q <= '0;
      nodesc_q    <= '0;
    end else begin
      if (op_valid_i && state_q == CCOS_IDLE) begin
        unique case (op)
          CCOS_OP_LOAD, CCOS_OP_STORE: begin
            if (!valid_q[op_chan_i]) nodesc_q[op_chan_i] <= 1'b1;
            else if (!xfer_seen_q[op_chan_i]) begin
              lastcpy_q[op_chan_i]   <= last_q[op_chan_i];
              xfer_seen_q[op_chan_i] <= 1'b1;
            end
          end
          CCOS_OP_GNB: if (valid_q[op_chan_i]) begin
            valid_q[op_chan_i]     <= 1'b0;
            xfer_seen_q[op_chan_i] <= 1'b0;
          end
          default: ;
        endcase
      end
      if (desc_ok) begin
        valid_q[desc_chan_i]  <= 1'b1;
        last_q[desc_chan_i]   <= desc_ctrl_i[`CCOS_BIT_DLAST];
        nodesc_q[desc_chan_i] <= 1'b0;
      end
      // The stalled load completes as the first transfer of the new block
      if (desc_late && !xfer_seen_q[ch_q]) begin
        lastcpy_q[ch_q]   <= desc_ctrl_i[`CCOS_BIT_DLAST];
        xfer_seen_q[ch_q] <= 1'b1;
      end
    end
  end

  // Buffer address and range, no end stop
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `CCOS_NCH; i++) begin
        addr_q[i]  <= 16'h0000;
        range_q[i] <= 16'h0000;
      end
    end else if (op_valid_i && state_q == CCOS_IDLE && valid_q[op_chan_i]
                 && (op == CCOS_OP_LOAD || op == CCOS_OP_STORE)) begin
      addr_q[op_chan_i]  <= addr_q[op_chan_i] + 16'h0001;
      range_q[op_chan_i] <= range_q[op_chan_i] - 16'h0001;
    end else if (desc_late) begin
      addr_q[ch_q]  <= addr_q[ch_q] + 16'h0001;
      range_q[ch_q] <= range_q[ch_q] - 16'h0001;
    end
  end

  // Operation sequencer
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= CCOS_IDLE;
      ch_q    <= 2'd0;
      wcnt_q  <= 12'h000;
      run_q   <= '0;
      for (int i = 0; i < `CCOS_NCH; i++) ctx_q[i] <= 8'h00;
    end else begin
      unique case (state_q)
        CCOS_IDLE: if (op_valid_i) begin
          ch_q <= op_chan_i;
          unique case (op)
            CCOS_OP_SYNC:  state_q <= CCOS_SYNC_LO;
            CCOS_OP_START: run_q[op_chan_i] <= 1'b1;
            CCOS_OP_LOAD:  if (!valid_q[op_chan_i]) state_q <= CCOS_DONE;
            CCOS_OP_WAIT: begin
              ctx_q[op_chan_i] <= {7'h00, op_tx_i};
              wcnt_q  <= 12'(`CCOS_WAIT_CYC - 1);
              state_q <= CCOS_WAITING;
            end
            default: ;
          endcase
        end else if (scan_hit && scan_ctl[`CCOS_BIT_SCANST] && !scan_ctl[`CCOS_BIT_SCANINT])
          run_q[scan_ch_q] <= 1'b1;
        CCOS_SYNC_LO: state_q <= CCOS_SYNC_HI;
        CCOS_SYNC_HI: state_q <= CCOS_IDLE;
        CCOS_WAITING: if (wcnt_q != 12'h000) wcnt_q <= wcnt_q - 12'h001;
          else begin
            run_q[ch_q] <= 1'b0;
            if (chan_req_i) state_q <= CCOS_RESTORE;
          end
        CCOS_RESTORE: begin
          run_q[ch_q] <= 1'b1;
          state_q <= CCOS_IDLE;
        end
        CCOS_DONE: if (desc_late) state_q <= CCOS_IDLE;
        default: state_q <= CCOS_IDLE;
      endcase
    end
  end

  // Line register and event outputs
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      line_wr_o    <= 1'b0;
      line_rd_o    <= 1'b0;
      line_wdata_o <= 8'h00;
      ctrl_wr_o    <= 1'b0;
      ctrl_wdata_o <= 8'h00;
      crc_en_o     <= 1'b0;
      crc_load_o   <= 1'b0;
      crc_size_o   <= 2'd0;
      rx_char_o    <= 8'h00;
      last_blk_o   <= 1'b0;
      host_irq_o   <= 1'b0;
      prog_start_o <= 1'b0;
      evt_chan_o   <= 2'd0;
    end else begin
      line_wr_o    <= 1'b0;
      line_rd_o    <= 1'b0;
      ctrl_wr_o    <= 1'b0;
      crc_load_o   <= 1'b0;
      host_irq_o   <= 1'b0;
      prog_start_o <= 1'b0;
      if (state_q == CCOS_IDLE && op_valid_i) begin
        unique case (op)
          CCOS_OP_SEND, CCOS_OP_RAW_TX: begin
            line_wr_o    <= 1'b1;
            line_wdata_o <= op_data_i;
            crc_en_o     <= (op == CCOS_OP_SEND);
          end
          CCOS_OP_RECEIVE_CHAR_OP, CCOS_OP_RAW_RX: begin
            line_rd_o <= 1'b1;
            rx_char_o <= line_rx_i;
            crc_en_o  <= (op == CCOS_OP_RECEIVE_CHAR_OP);
          end
          CCOS_OP_BLB:  last_blk_o <= lastcpy_q[op_chan_i];
          CCOS_OP_HOST_INTERRUPT_OP: begin
            host_irq_o <= 1'b1;
            evt_chan_o <= op_chan_i;
          end
          default: ;
        endcase
      end else if (scan_hit) begin
        evt_chan_o <= scan_ch_q;
        if (scan_ctl[`CCOS_BIT_SCANINT]) host_irq_o <= 1'b1;
        else if (scan_ctl[`CCOS_BIT_SCANST]) prog_start_o <= 1'b1;
      end
      if (state_q == CCOS_SYNC_LO) begin
        ctrl_wr_o    <= 1'b1;
        ctrl_wdata_o <= tbl_q[ch_q][`CCOS_TBL_CTRL] & ~(8'h01 << `CCOS_BIT_RXON);
      end
      if (state_q == CCOS_SYNC_HI) begin
        ctrl_wr_o    <= 1'b1;
        ctrl_wdata_o <= tbl_q[ch_q][`CCOS_TBL_CTRL] | (8'h01 << `CCOS_BIT_RXON);
      end
      if (state_q == CCOS_RESTORE) begin
        crc_load_o <= 1'b1;
        crc_size_o <= 2'((ctx_q[ch_q][0] ? tbl_q[ch_q][`CCOS_TBL_CFG_TX]
                                         : tbl_q[ch_q][`CCOS_TBL_CFG_RX]) & `CCOS_CSIZE_MSK);
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n)        tbl_rdata_o <= 8'h00;
    else if (tbl_re_i) tbl_rdata_o <= tbl_q[tbl_chan_i][tbl_addr_i];
  end

  assign desc_valid_o = valid_q[op_chan_i];
  assign buf_addr_o   = addr_q[op_chan_i];
  assign buf_range_o  = range_q[op_chan_i];
  assign busy_o       = state_q != CCOS_IDLE;
  assign stall_o      = state_q == CCOS_DONE;
endmodule : ccos_sequencer

// File: testbench/ccos_sequencer_chk.sv
// Port assertions of the channel operation sequencer
`timescale 1ns/1ps
module ccos_sequencer_chk
  import ccos_pkg::*;
(
  input wire logic        mclk_i,       // Clock
  input wire logic        arst_n_i,     // Reset
  input wire logic        op_valid_i,   // Op strobe
  input wire logic [3:0]  op_code_i,    // Op code
  input wire logic [1:0]  op_chan_i,    // Channel
  input wire logic [7:0]  op_data_i,    // Char
  input wire logic        chan_req_i,   // Resume
  input wire logic        desc_set_i,   // Descr write
  input wire logic [7:0]  desc_ctrl_i,  // Descr ctrl
  input wire logic        line_wr_o,    // Data write
  input wire logic        line_rd_o,    // Data read
  input wire logic [7:0]  line_wdata_o, // Write value
  input wire logic        ctrl_wr_o,    // Ctrl write
  input wire logic [7:0]  ctrl_wdata_o, // Ctrl value
  input wire logic        crc_en_o,     // CRC on
  input wire logic        crc_load_o,   // Size load
  input wire logic        desc_valid_o, // Valid bit
  input wire logic [15:0] buf_addr_o,   // Address
  input wire logic [15:0] buf_range_o,  // Range
  input wire logic        busy_o,       // Busy
  input wire logic        stall_o,      // Stall
  input wire logic        host_irq_o,   // Irq
  input wire logic        prog_start_o  // Start
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  logic go;
  assign go = op_valid_i && !busy_o;
  property p_send; go && op_code_i == CCOS_OP_SEND |=> line_wr_o && crc_en_o && line_wdata_o == $past(op_data_i); endproperty
  property p_raw_tx; go && op_code_i == CCOS_OP_RAW_TX |=> line_wr_o && !crc_en_o && line_wdata_o == $past(op_data_i); endproperty
  property p_raw_rx; go && op_code_i == CCOS_OP_RAW_RX |=> line_rd_o && !crc_en_o; endproperty
  property p_receive_char_op; go && op_code_i == CCOS_OP_RECEIVE_CHAR_OP |=> line_rd_o && crc_en_o; endproperty
  property p_host_interrupt_op; go && op_code_i == CCOS_OP_HOST_INTERRUPT_OP |=> host_irq_o; endproperty
  property p_sync; $rose(ctrl_wr_o) |-> !ctrl_wdata_o[2] ##1 ctrl_wr_o && ctrl_wdata_o == ($past(ctrl_wdata_o) | 8'h04); endproperty
  property p_stall; $fell(stall_o) |-> $past(desc_set_i && desc_ctrl_i[1]); endproperty
  property p_wait; go && op_code_i == CCOS_OP_WAIT |=> busy_o [*8]; endproperty
  property p_restore; crc_load_o |-> $past(chan_req_i, 2); endproperty
  property p_gnb; go && op_code_i == CCOS_OP_GNB |=> !desc_valid_o || op_chan_i != $past(op_chan_i); endproperty
  property p_count;
    $stable(op_chan_i) && buf_addr_o != $past(buf_addr_o)
      |-> buf_addr_o == $past(buf_addr_o) + 16'h0001 && buf_range_o == $past(buf_range_o) - 16'h0001;
  endproperty
  property p_prio; !(host_irq_o && prog_start_o); endproperty
  a_send: assert property (p_send) else $error("send write wrong");
  a_raw_tx: assert property (p_raw_tx) else $error("raw transmit wrong");
  a_raw_rx: assert property (p_raw_rx) else $error("raw receive wrong");
  a_receive_char_op: assert property (p_receive_char_op) else $error("receive read wrong");
  a_host_interrupt_op: assert property (p_host_interrupt_op) else $error("no host interrupt");
  a_sync: assert property (p_sync) else $error("sync search pair wrong");
  a_stall: assert property (p_stall) else $error("stall left early");
  a_wait: assert property (p_wait) else $error("wait ended early");
  a_restore: assert property (p_restore) else $error("restore without request");
  a_gnb: assert property (p_gnb) else $error("valid bit kept");
  a_count: assert property (p_count) else $error("address and range out of step");
  a_prio: assert property (p_prio) else $error("start beside interrupt");
  c_sync: cover property ($rose(ctrl_wr_o));
  c_irq: cover property (host_irq_o);
  c_start: cover property (prog_start_o);
  c_stall: cover property ($fell(stall_o));
endmodule : ccos_sequencer_chk

// File: testbench/ccos_line_model.sv
// Line adapter model: status register and loop-back data register
`timescale 1ns/1ps
module ccos_line_model (
  input  wire logic       mclk_i,        // Clock
  input  wire logic       arst_n_i,      // Reset
  input  wire logic [7:0] status_i,      // Status to show
  input  wire logic       line_wr_i,     // Data write
  input  wire logic [7:0] line_wdata_i,  // Write value
  input  wire logic       line_rd_i,     // Data read
  output logic      [7:0] line_status_o, // Status register
  output logic      [7:0] line_rx_o      // Data register
);
  logic [7:0] data_q;
  // A char once read is gone; show its inverse so stale reads show up
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      data_q <= 8'h00;
    end else if (line_wr_i) begin
      data_q <= line_wdata_i;
    end else if (line_rd_i) begin
      data_q <= ~data_q;
    end
  end
  assign line_rx_o     = data_q;
  assign line_status_o = status_i;
endmodule : ccos_line_model

// File: testbench/ccos_sequencer_bench.sv
// Self-checking bench of the channel operation sequencer
`timescale 1ns/1ps
module ccos_sequencer_bench
  import ccos_pkg::*;
;
  typedef struct packed {
    ccos_op_t op; logic tx; logic [7:0] data, status, preset; logic [5:0] addr; logic [7:0] exp; logic [3:0] flags;
  } ccos_row_t;
  logic        mclk_i = 1'b0, arst_n_i = 1'b0, op_valid_i = 1'b0, op_tx_i = 1'b0, chan_req_i = 1'b0;
  logic        desc_set_i = 1'b0, tbl_we_i = 1'b0, tbl_re_i = 1'b0;
  logic [3:0]  op_code_i = 4'h0;
  logic [1:0]  op_chan_i = 2'h0, desc_chan_i = 2'h0, tbl_chan_i = 2'h0, crc_size_o, evt_chan_o;
  logic [5:0]  tbl_addr_i = 6'h00;
  logic [7:0]  op_data_i = 8'h00, desc_ctrl_i = 8'h00, tbl_wdata_i = 8'h00, status = 8'h00;
  logic [7:0]  tbl_rdata_o, line_status_i, line_rx_i, line_wdata_o, ctrl_wdata_o, rx_char_o;
  logic [15:0] buf_addr_o, buf_range_o;
  logic        line_wr_o, line_rd_o, ctrl_wr_o, crc_en_o, crc_load_o, last_blk_o;
  logic        desc_valid_o, busy_o, stall_o, host_irq_o, prog_start_o;
  int          n_errors = 0, n_checks = 0, i;
  ccos_row_t   rows [5] = '{'{CCOS_OP_SEND, 1'b1, 8'ha5, 8'h80, 8'h01, 6'h30, 8'h05, 4'ha},
                            '{CCOS_OP_RECEIVE_CHAR_OP, 1'b0, 8'ha5, 8'h40, 8'h80, 6'h10, 8'h84, 4'h6},
                            '{CCOS_OP_RAW_TX, 1'b1, 8'h3c, 8'h80, 8'h01, 6'h30, 8'h01, 4'h8},
                            '{CCOS_OP_RAW_RX, 1'b0, 8'h3c, 8'h40, 8'h80, 6'h10, 8'h80, 4'h4},
                            '{CCOS_OP_HOST_INTERRUPT_OP, 1'b0, 8'h00, 8'h00, 8'hff, 6'h10, 8'h01, 4'h1}};
  always #50 mclk_i = ~mclk_i;
  ccos_sequencer dut (.mclk_i, .arst_n_i, .op_valid_i, .op_code_i, .op_chan_i, .op_tx_i, .op_data_i, .chan_req_i,
    .desc_set_i, .desc_chan_i, .desc_ctrl_i, .tbl_we_i, .tbl_chan_i, .tbl_addr_i, .tbl_wdata_i, .tbl_re_i,
    .tbl_rdata_o, .line_status_i, .line_rx_i, .line_wr_o, .line_rd_o, .line_wdata_o, .ctrl_wr_o, .ctrl_wdata_o,
    .crc_en_o, .crc_load_o, .crc_size_o, .rx_char_o, .last_blk_o, .desc_valid_o, .buf_addr_o, .buf_range_o,
    .busy_o, .stall_o, .host_irq_o, .prog_start_o, .evt_chan_o);
  ccos_line_model model (.mclk_i, .arst_n_i, .status_i(status), .line_wr_i(line_wr_o), .line_wdata_i(line_wdata_o),
    .line_rd_i(line_rd_o), .line_status_o(line_status_i), .line_rx_o(line_rx_i));
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic stuck;
    n_errors++;
    $display("timeout at %0t", $time);
    wrap_up;
  endtask : stuck
  task automatic wr(input logic [1:0] c, input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    {tbl_we_i, tbl_chan_i, tbl_addr_i, tbl_wdata_i} <= {1'b1, c, a, d};
    @(posedge mclk_i);
    tbl_we_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] c, input logic [5:0] a, input logic [7:0] e);
    @(posedge mclk_i);
    {tbl_re_i, tbl_chan_i, tbl_addr_i} <= {1'b1, c, a};
    @(posedge mclk_i);
    tbl_re_i <= 1'b0;
    @(negedge mclk_i);
    chk(tbl_rdata_o, e);
  endtask : rd
  task automatic op(input ccos_op_t c, input logic [1:0] ch, input logic t, input logic [7:0] d);
    for (int k = 0; k < 400 && busy_o !== 1'b0; k++) @(negedge mclk_i);
    if (busy_o !== 1'b0) stuck;
    @(posedge mclk_i);
    {op_valid_i, op_code_i, op_chan_i, op_tx_i, op_data_i} <= {1'b1, c, ch, t, d};
    @(posedge mclk_i);
    op_valid_i <= 1'b0;
    @(negedge mclk_i);
  endtask : op
  task automatic wait_ev(input int w);
    logic [2:0] e;
    for (int k = 0; k < 300; k++) begin
      @(negedge mclk_i);
      e = {prog_start_o, host_irq_o, crc_load_o};
      if (e[w] === 1'b1) return;
    end
    stuck;
  endtask : wait_ev
  task automatic descr(input logic [7:0] c);
    @(posedge mclk_i);
    {desc_set_i, desc_chan_i, desc_ctrl_i} <= {1'b1, 2'h3, c};
    @(posedge mclk_i);
    desc_set_i <= 1'b0;
    repeat (4) @(negedge mclk_i);
  endtask : descr
  initial begin
    repeat (4) @(posedge mclk_i);
    #1 chk({busy_o, stall_o, line_wr_o, ctrl_wr_o, host_irq_o}, 5'h00);
    repeat (4) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    for (i = 0; i < 8; i++) wr(i[2:1], {i[0], 5'h08}, 8'h00);
    for (i = 0; i < 5; i++) begin
      wr(2'h0, rows[i].addr, rows[i].preset);
      status <= rows[i].status;
      op(rows[i].op, 2'h0, rows[i].tx, rows[i].data);
      chk({line_wr_o, line_rd_o, crc_en_o, host_irq_o}, rows[i].flags);
      if (rows[i].flags[3:2] != 2'b00) chk(rows[i].flags[3] ? line_wdata_o : rx_char_o, rows[i].data);
      rd(2'h0, rows[i].addr, rows[i].exp);
    end
    $display("operation rows done");
    wr(2'h1, 6'h14, 8'h35);
    op(CCOS_OP_SYNC, 2'h1, 1'b0, 8'h00);
    @(negedge mclk_i);
    chk({ctrl_wr_o, ctrl_wdata_o}, 9'h131);
    @(negedge mclk_i);
    chk({ctrl_wr_o, ctrl_wdata_o}, 9'h135);
    $display("sync search done");
    wr(2'h2, 6'h02, 8'hf3);
    wr(2'h2, 6'h22, 8'h01);
    for (i = 0; i < 2; i++) begin
      op(CCOS_OP_WAIT, 2'h2, i[0], 8'h00);
      repeat (160) @(negedge mclk_i);
      chk(busy_o, 1'b1);
      @(posedge mclk_i) chan_req_i <= 1'b1;
      wait_ev(0);
      chk(crc_size_o, i[0] ? 2'h1 : 2'h3);
      @(posedge mclk_i) chan_req_i <= 1'b0;
    end
    $display("wait and restore done");
    wr(2'h3, 6'h30, 8'h00);
    op(CCOS_OP_LOAD, 2'h3, 1'b0, 8'h00);
    repeat (20) @(negedge mclk_i);
    chk({stall_o, busy_o}, 2'b11);
    descr(8'h06);
    rd(2'h3, 6'h30, 8'h10);
    chk({buf_addr_o, buf_range_o}, 32'h0001ffff);
    op(CCOS_OP_BLB, 2'h3, 1'b0, 8'h00);
    chk(last_blk_o, 1'b1);
    op(CCOS_OP_GNB, 2'h3, 1'b0, 8'h00);
    chk(desc_valid_o, 1'b0);
    op(CCOS_OP_STORE, 2'h3, 1'b0, 8'h00);
    chk({stall_o, buf_addr_o, buf_range_o}, 33'h00001ffff);
    $display("descriptor handling done");
    wr(2'h0, 6'h0f, 8'h0f);
    wr(2'h0, 6'h0e, 8'h00);
    wr(2'h0, 6'h11, 8'h00);
    status <= 8'h80;
    wr(2'h0, 6'h08, 8'h0d);
    repeat (30) @(negedge mclk_i);
    rd(2'h0, 6'h11, 8'h00);
    rd(2'h0, 6'h0e, 8'h80);
    @(posedge mclk_i) status <= 8'h81;
    wait_ev(1);
    chk({prog_start_o, evt_chan_o}, 3'h0);
    rd(2'h0, 6'h11, 8'h08);
    wr(2'h0, 6'h08, 8'h00);
    wr(2'h1, 6'h0f, 8'h0f);
    wr(2'h1, 6'h0e, 8'h81);
    wr(2'h1, 6'h08, 8'h09);
    @(posedge mclk_i) status <= 8'h83;
    wait_ev(2);
    chk({host_irq_o, evt_chan_o}, 3'h1);
    @(posedge mclk_i) status <= 8'h87;
    repeat (20) @(negedge mclk_i);
    rd(2'h1, 6'h0e, 8'h83);
    $display("status scan done");
    wrap_up;
  end
endmodule : ccos_sequencer_bench
bind ccos_sequencer ccos_sequencer_chk chk (.mclk_i, .arst_n_i, .op_valid_i, .op_code_i, .op_chan_i, .op_data_i,
  .chan_req_i, .desc_set_i, .desc_ctrl_i, .line_wr_o, .line_rd_o, .line_wdata_o, .ctrl_wr_o, .ctrl_wdata_o,
  .crc_en_o, .crc_load_o, .desc_valid_o, .buf_addr_o, .buf_range_o, .busy_o, .stall_o, .host_irq_o, .prog_start_o);
